// >>> rtl/oag_operand_address_generator.sv
// Operand address generator: resolves operands and branch targets per mode.
`timescale 1ns/10ps

// How it works
// - Each instruction accepts only its own modes.
// - Register mode reads named register or pair.
// - Working address is pointer space plus index.
// - Indirect register contents become the operand address.
// - Byte registers point registers, pairs point memory.
// - Indirect register cannot reach upper control set.
// - Indexed cannot reach upper control set.
// - Short offset is sign-extended, memory only.
// - Register indexed adds base and working offset.
// - Memory indexed adds offset to working pair.
// - Indexed only for the three load kinds.
// - Absolute address loads the program counter for jump and call.
// - Memory loads take absolute source or destination.
// - Vectored call reads pointer pair in low page.
// - Vector pointer upper bits forced to zero.
// - Relative target is counter plus signed displacement.
// - Counter already points past the branch.
// - Exactly six instructions use relative mode.
// - Literal mode takes the byte or word itself.
module oag_operand_address_generator (
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   req_valid_i,
  input  wire oag_pkg::oag_instr_type req_instr_i,
  input  wire oag_pkg::oag_mode_type  req_mode_i,
  input  wire logic                   req_word_i,
  input  wire logic                   req_work_i,
  input  wire logic                   req_long_i,
  input  wire logic [7:0]             req_reg_i,
  input  wire logic [7:0]             req_disp_i,
  input  wire logic [15:0]            req_imm_i,
  input  wire logic [15:0]            pc_next_i,
  input  wire logic [7:0]             reg_ptr_i,
  input  wire logic [7:0]             rd_data_i,
  output logic                        req_ready_o,
  output logic                        rd_o,
  output oag_pkg::oag_space_type      rd_space_o,
  output logic [15:0]                 rd_addr_o,
  output logic                        done_o,
  output logic                        fault_o,
  output logic [15:0]                 ea_o,
  output oag_pkg::oag_space_type      ea_space_o,
  output logic                        ea_valid_o,
  output logic [15:0]                 operand_o,
  output logic                        operand_valid_o,
  output logic                        pc_load_o
);
  import oag_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CALC,
    ST_RD_HI,
    ST_RD_LO,
    ST_CAPT
  } oag_state_type;

  // Working register address: pointer chooses the 8-byte space, field the byte.
  function automatic logic [7:0] reg_addr(input logic [7:0] field, input logic work,
                                          input logic [7:0] rp);
    reg_addr = work ? {rp[7:OAG_WORK_INDEX_BITS], field[OAG_WORK_INDEX_BITS-1:0]} : field;
  endfunction : reg_addr

  // Space an indirect or indexed access lands in, set by the instruction.
  function automatic oag_space_type space_of(input oag_instr_type instr);
    space_of = (instr == OAG_PROGRAM_MEMORY_LOAD) ? OAG_SPACE_PROGRAM :
               (instr == OAG_EXTERNAL_DATA_LOAD)  ? OAG_SPACE_EXTERNAL :
                                                    OAG_SPACE_REGISTER_FILE;
  endfunction : space_of

  logic [1:0]    rst_sync;
  logic          rst_n;
  oag_state_type state;
  oag_state_type next_state;

  oag_instr_type instr_q;
  oag_mode_type  mode_q;
  logic          word_q;
  logic          long_q;
  logic          legal_q;
  logic          fetch_word_q;
  logic [7:0]    disp_q;
  logic [15:0]   imm_q;
  logic [15:0]   pc_q;
  logic [7:0]    hi_q;

  // Reset is released through two flops so every flop after them leaves reset together.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Request side decode, valid while idle.
  logic          req_legal;
  logic          req_take;
  logic          req_fetch;
  logic          req_fetch_word;
  oag_space_type req_fetch_space;
  logic [15:0]   req_fetch_addr;
  logic          req_mem_target;
  logic [7:0]    req_reg_addr;

  oag_mode_legal u_legal (
    .instr_i (req_instr_i),
    .mode_i  (req_mode_i),
    .legal_o (req_legal)
  );

  assign req_take       = req_valid_i && req_ready_o && (state == ST_IDLE);
  assign req_mem_target = (space_of(req_instr_i) != OAG_SPACE_REGISTER_FILE);
  assign req_reg_addr   = reg_addr(req_reg_i, req_work_i, reg_ptr_i);

  // Only legal requests that need register or vector contents fetch anything.
  assign req_fetch = req_legal && ((req_mode_i == OAG_REGISTER_MODE) ||
                                   (req_mode_i == OAG_REGISTER_INDIRECT_MODE) ||
                                   (req_mode_i == OAG_INDEXED_MODE) ||
                                   (req_mode_i == OAG_VECTORED_ADDRESS_MODE));

  // pairs point memory, bytes point registers
  assign req_fetch_word =
    (req_mode_i == OAG_REGISTER_MODE)          ? req_word_i :
    (req_mode_i == OAG_REGISTER_INDIRECT_MODE) ? req_mem_target :
    (req_mode_i == OAG_INDEXED_MODE)           ? req_mem_target :
    (req_mode_i == OAG_VECTORED_ADDRESS_MODE);

  assign req_fetch_space = (req_mode_i == OAG_VECTORED_ADDRESS_MODE) ? OAG_SPACE_PROGRAM :
                                                                       OAG_SPACE_REGISTER_FILE;

  assign req_fetch_addr =
    (req_mode_i == OAG_VECTORED_ADDRESS_MODE) ? {OAG_VECTOR_PAGE, req_disp_i} :
    (req_mode_i == OAG_INDEXED_MODE)          ? {8'h00, reg_addr(req_reg_i, 1'b1, reg_ptr_i)} :
                                                {8'h00, req_reg_addr};

  // Finish side: the fetched value and the address arithmetic.
  logic [15:0]   fetched;
  logic [15:0]   add_base;
  logic [15:0]   add_offset;
  logic          add_long;
  logic [15:0]   add_sum;
  logic [7:0]    rf_index_sum;
  logic          finish;
  logic          fin_fault;
  logic [15:0]   fin_ea;
  oag_space_type fin_space;
  logic          fin_ea_valid;
  logic [15:0]   fin_operand;
  logic          fin_operand_valid;
  logic          fin_pc_load;
  logic          target_rf;
  logic          is_jump;

  assign fetched = fetch_word_q ? {hi_q, rd_data_i} : {8'h00, rd_data_i};

  assign add_base   = (mode_q == OAG_PC_RELATIVE_MODE) ? pc_q : fetched;
  assign add_offset = long_q ? imm_q : {8'h00, disp_q};
  assign add_long   = long_q && (mode_q == OAG_INDEXED_MODE);

  oag_offset_add u_add (
    .base_i   (add_base),
    .offset_i (add_offset),
    .long_i   (add_long),
    .sum_o    (add_sum)
  );

  assign rf_index_sum = imm_q[7:0] + fetched[7:0];
  assign target_rf    = (space_of(instr_q) == OAG_SPACE_REGISTER_FILE);
  assign is_jump      = (instr_q == OAG_ABSOLUTE_JUMP) || (instr_q == OAG_CALL);
  assign finish       = (state == ST_CALC) || (state == ST_CAPT);

  always_comb begin
    fin_fault         = !legal_q;
    fin_ea            = OAG_RESET_WORD;
    fin_space         = OAG_SPACE_REGISTER_FILE;
    fin_ea_valid      = 1'b0;
    fin_operand       = OAG_RESET_WORD;
    fin_operand_valid = 1'b0;
    fin_pc_load       = 1'b0;
    if (legal_q) begin
      case (mode_q)
        OAG_REGISTER_MODE: begin
          fin_operand       = fetched;
          fin_operand_valid = 1'b1;
        end
        OAG_REGISTER_INDIRECT_MODE: begin
          fin_ea       = fetched;
          fin_space    = space_of(instr_q);
          fin_ea_valid = 1'b1;
          fin_fault    = target_rf && (fetched[7:0] >= OAG_UPPER_SET_BASE);
        end
        OAG_INDEXED_MODE: begin
          fin_space    = space_of(instr_q);
          fin_ea_valid = 1'b1;
          if (target_rf) begin
            fin_ea    = {8'h00, rf_index_sum};
            fin_fault = (rf_index_sum >= OAG_UPPER_SET_BASE);
          end else begin
            // pair plus short or long offset
            fin_ea = add_sum;
          end
        end
        OAG_ABSOLUTE_ADDRESS_MODE: begin
          fin_ea       = imm_q;
          fin_ea_valid = 1'b1;
          if (is_jump) begin
            fin_space   = OAG_SPACE_PC;
            fin_pc_load = 1'b1;
          end else begin
            fin_space = space_of(instr_q);
          end
        end
        OAG_VECTORED_ADDRESS_MODE: begin
          fin_ea       = fetched;
          fin_space    = OAG_SPACE_PC;
          fin_ea_valid = 1'b1;
          fin_pc_load  = 1'b1;
        end
        OAG_PC_RELATIVE_MODE: begin
          fin_ea       = add_sum;
          fin_space    = OAG_SPACE_PC;
          fin_ea_valid = 1'b1;
          fin_pc_load  = 1'b1;
        end
        OAG_LITERAL_OPERAND_MODE: begin
          fin_operand       = word_q ? imm_q : {8'h00, imm_q[7:0]};
          fin_operand_valid = 1'b1;
        end
        default: begin
          fin_fault = 1'b1;
        end
      endcase
    end
  end

  // Sequencer: one fetch of one or two bytes at most per request.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req_take) begin
          next_state = req_fetch ? ST_RD_HI : ST_CALC;
        end
      end
      ST_RD_HI: begin
        next_state = fetch_word_q ? ST_RD_LO : ST_CAPT;
      end
      ST_RD_LO: begin
        next_state = ST_CAPT;
      end
      ST_CALC: begin
        next_state = ST_IDLE;
      end
      ST_CAPT: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Request is held in flops so the decoder may move on once accepted.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      instr_q      <= OAG_GENERIC_INSTR;
      mode_q       <= OAG_REGISTER_MODE;
      word_q       <= 1'b0;
      long_q       <= 1'b0;
      legal_q      <= 1'b0;
      fetch_word_q <= 1'b0;
      disp_q       <= OAG_RESET_BYTE;
      imm_q        <= OAG_RESET_WORD;
      pc_q         <= OAG_RESET_WORD;
    end else if (req_take) begin
      instr_q      <= req_instr_i;
      mode_q       <= req_mode_i;
      word_q       <= req_word_i;
      long_q       <= req_long_i;
      legal_q      <= req_legal;
      fetch_word_q <= req_fetch_word;
      disp_q       <= req_disp_i;
      imm_q        <= req_imm_i;
      pc_q         <= pc_next_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= OAG_RESET_BYTE;
    end else if (state == ST_RD_LO) begin
      hi_q <= rd_data_i;
    end
  end

  // Read port: the strobe stands one cycle per byte, data returns on the next.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_o       <= 1'b0;
      rd_space_o <= OAG_SPACE_REGISTER_FILE;
      rd_addr_o  <= OAG_RESET_WORD;
    end else if (req_take && req_fetch) begin
      rd_o       <= 1'b1;
      rd_space_o <= req_fetch_space;
      rd_addr_o  <= req_fetch_addr;
    end else if ((state == ST_RD_HI) && fetch_word_q) begin
      rd_o      <= 1'b1;
      rd_addr_o <= rd_addr_o + OAG_PAIR_STEP;
    end else begin
      rd_o <= 1'b0;
    end
  end

  // Results other than the pc_load_o pulse stand from the done pulse until the next request completes.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      done_o          <= 1'b0;
      fault_o         <= 1'b0;
      ea_o            <= OAG_RESET_WORD;
      ea_space_o      <= OAG_SPACE_REGISTER_FILE;
      ea_valid_o      <= 1'b0;
      operand_o       <= OAG_RESET_WORD;
      operand_valid_o <= 1'b0;
      pc_load_o       <= 1'b0;
    end else begin
      done_o    <= finish;
      pc_load_o <= finish && fin_pc_load && !fin_fault;
      if (finish) begin
        fault_o         <= fin_fault;
        ea_o            <= fin_ea;
        ea_space_o      <= fin_space;
        ea_valid_o      <= fin_ea_valid && !fin_fault;
        operand_o       <= fin_operand;
        operand_valid_o <= fin_operand_valid && !fin_fault;
      end
    end
  end

  // Ready drops the cycle after a request is taken, so back-to-back offers wait.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= (next_state == ST_IDLE);
    end
  end

endmodule : oag_operand_address_generator

// >>> common/oag_pkg.sv
// Shared types and constants for the operand address generator.
package oag_pkg;

  // Explicit operand addressing modes; working register access is register mode
  // with the working select set.
  typedef enum logic [2:0] {
    OAG_REGISTER_MODE,
    OAG_REGISTER_INDIRECT_MODE,
    OAG_INDEXED_MODE,
    OAG_ABSOLUTE_ADDRESS_MODE,
    OAG_VECTORED_ADDRESS_MODE,
    OAG_PC_RELATIVE_MODE,
    OAG_LITERAL_OPERAND_MODE
  } oag_mode_type;

  // Instruction classes that the decoder hands over.
  typedef enum logic [3:0] {
    OAG_GENERIC_INSTR,
    OAG_PLAIN_LOAD,
    OAG_PROGRAM_MEMORY_LOAD,
    OAG_EXTERNAL_DATA_LOAD,
    OAG_ABSOLUTE_JUMP,
    OAG_CALL,
    OAG_BIT_TEST_FALSE_BRANCH,
    OAG_BIT_TEST_TRUE_BRANCH,
    OAG_DECREMENT_BRANCH_NONZERO,
    OAG_COMPARE_INCREMENT_JUMP_EQUAL,
    OAG_COMPARE_INCREMENT_JUMP_NOT_EQUAL,
    OAG_RELATIVE_JUMP
  } oag_instr_type;

  // Address spaces an effective address or a fetch can point into.
  typedef enum logic [1:0] {
    OAG_SPACE_REGISTER_FILE,
    OAG_SPACE_PROGRAM,
    OAG_SPACE_EXTERNAL,
    OAG_SPACE_PC
  } oag_space_type;

  // First location of the upper control register set.
  localparam logic [7:0]  OAG_UPPER_SET_BASE  = 8'hC0;
  // Index bits inside the 8-byte working register space.
  localparam int          OAG_WORK_INDEX_BITS = 3;
  // High byte of every vector pointer address.
  localparam logic [7:0]  OAG_VECTOR_PAGE     = 8'h00;
  // Step from the high byte of a pair to its low byte.
  localparam logic [15:0] OAG_PAIR_STEP       = 16'h0001;
  localparam logic [15:0] OAG_RESET_WORD      = 16'h0000;
  localparam logic [7:0]  OAG_RESET_BYTE      = 8'h00;

endpackage : oag_pkg

// >>> rtl/oag_offset_add.sv
// Base plus signed short or full long offset adder.
`timescale 1ns/10ps
module oag_offset_add (
  input  wire logic [15:0] base_i,
  input  wire logic [15:0] offset_i,
  input  wire logic        long_i,
  output wire logic [15:0] sum_o
);
  logic [15:0] ext_offset;

  assign ext_offset = long_i ? offset_i : {{8{offset_i[7]}}, offset_i[7:0]};
  assign sum_o      = base_i + ext_offset;

endmodule : oag_offset_add

// >>> rtl/oag_mode_legal.sv
// Tells whether an instruction class may use a given addressing mode.
`timescale 1ns/10ps
module oag_mode_legal (
  input  wire oag_pkg::oag_instr_type instr_i,
  input  wire oag_pkg::oag_mode_type  mode_i,
  output wire logic                   legal_o
);
  import oag_pkg::*;

  logic is_branch;
  logic is_mem_load;

  assign is_branch = (instr_i == OAG_BIT_TEST_FALSE_BRANCH) ||
                     (instr_i == OAG_BIT_TEST_TRUE_BRANCH) ||
                     (instr_i == OAG_DECREMENT_BRANCH_NONZERO) ||
                     (instr_i == OAG_COMPARE_INCREMENT_JUMP_EQUAL) ||
                     (instr_i == OAG_COMPARE_INCREMENT_JUMP_NOT_EQUAL) ||
                     (instr_i == OAG_RELATIVE_JUMP);
  assign is_mem_load = (instr_i == OAG_PROGRAM_MEMORY_LOAD) ||
                       (instr_i == OAG_EXTERNAL_DATA_LOAD);

  assign legal_o =
    (mode_i == OAG_INDEXED_MODE)          ? (is_mem_load || instr_i == OAG_PLAIN_LOAD) :
    (mode_i == OAG_ABSOLUTE_ADDRESS_MODE) ? (is_mem_load || instr_i == OAG_ABSOLUTE_JUMP ||
                                             instr_i == OAG_CALL) :
    (mode_i == OAG_VECTORED_ADDRESS_MODE) ? (instr_i == OAG_CALL) :
    (mode_i == OAG_PC_RELATIVE_MODE)      ? is_branch :
    (mode_i == OAG_LITERAL_OPERAND_MODE)  ? !is_mem_load :
    (mode_i == OAG_REGISTER_MODE)         ? 1'b1 :
    (mode_i == OAG_REGISTER_INDIRECT_MODE);

endmodule : oag_mode_legal

// >>> testbench/oag_checker.sv
// Concurrent checks on the ports of the operand address generator.
`timescale 1ns/10ps
module oag_checker
  import oag_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          resetn_i,
  input wire logic          req_valid_i,
  input wire oag_instr_type req_instr_i,
  input wire oag_mode_type  req_mode_i,
  input wire logic [7:0]    req_disp_i,
  input wire logic [15:0]   pc_next_i,
  input wire logic          req_ready_o,
  input wire logic          rd_o,
  input wire logic [15:0]   rd_addr_o,
  input wire logic          done_o,
  input wire logic          fault_o,
  input wire logic [15:0]   ea_o,
  input wire oag_space_type ea_space_o,
  input wire logic          ea_valid_o,
  input wire logic          operand_valid_o,
  input wire logic          pc_load_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  wire          take = req_valid_i && req_ready_o;
  oag_mode_type mode_q;
  logic [15:0]  rel_q;

  // Mode and branch target are kept from the take so later cycles can be judged.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= OAG_REGISTER_MODE;
      rel_q  <= 16'h0000;
    end else if (take) begin
      mode_q <= req_mode_i;
      rel_q  <= pc_next_i + {{8{req_disp_i[7]}}, req_disp_i};
    end
  end

  a_take_answered: assert property (
    take |=> !req_ready_o && !done_o ##[1:3] done_o) else $error("request not answered");
  a_done_single: assert property (
    done_o |=> !done_o) else $error("done longer than one cycle");
  a_fault_clears: assert property (
    done_o && fault_o |-> !ea_valid_o && !operand_valid_o && !pc_load_o)
    else $error("fault with valid results");
  a_pc_load_done: assert property (
    pc_load_o |-> done_o) else $error("pc load without done");
  a_absolute_no_read: assert property (
    take && req_mode_i == OAG_ABSOLUTE_ADDRESS_MODE |=> !rd_o ##1 done_o)
    else $error("absolute mode timing wrong");
  a_pair_next_byte: assert property (
    rd_o && $past(rd_o) |-> rd_addr_o == $past(rd_addr_o) + 16'h0001)
    else $error("pair low byte not at next address");
  a_vector_low_page: assert property (
    rd_o && mode_q == OAG_VECTORED_ADDRESS_MODE |-> rd_addr_o[15:8] == 8'h00)
    else $error("vector read outside low page");
  a_relative_target: assert property (
    take && req_mode_i == OAG_PC_RELATIVE_MODE && req_instr_i == OAG_RELATIVE_JUMP
    |-> ##2 done_o && pc_load_o && ea_o == rel_q) else $error("relative target wrong");
  a_upper_set_blocked: assert property (
    done_o && ea_valid_o && ea_space_o == OAG_SPACE_REGISTER_FILE
    && mode_q inside {OAG_REGISTER_INDIRECT_MODE, OAG_INDEXED_MODE}
    |-> ea_o[7:0] < OAG_UPPER_SET_BASE) else $error("upper control set reached");
endmodule : oag_checker

bind oag_operand_address_generator oag_checker oag_checker_i (
  .clk_i, .resetn_i, .req_valid_i, .req_instr_i, .req_mode_i, .req_disp_i, .pc_next_i,
  .req_ready_o, .rd_o, .rd_addr_o, .done_o, .fault_o, .ea_o, .ea_space_o, .ea_valid_o,
  .operand_valid_o, .pc_load_o
);

// >>> testbench/oag_mem_model.sv
// Register file and program memory answering one byte the cycle after each strobe.
`timescale 1ns/10ps
module oag_mem_model
  import oag_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rd_i,
  input  wire oag_space_type space_i,
  input  wire logic [15:0]   addr_i,
  output logic [7:0]         data_o
);
  initial data_o = 8'h00;
  always @(posedge clk_i) begin
    if (rd_i) begin
      data_o <= addr_i[7:0] ^ addr_i[15:8] ^ ((space_i == OAG_SPACE_PROGRAM) ? 8'hA5 : 8'h3C);
    end else begin
      // Stale data is inverted so a late sample never matches by chance.
      data_o <= ~data_o;
    end
  end
endmodule : oag_mem_model

// >>> testbench/oag_operand_address_generator_bench.sv
// Self-checking bench: requests in every addressing mode against a memory model.
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module oag_operand_address_generator_bench;
  import oag_pkg::*;
  typedef struct packed {
    logic flt; logic eac; logic [15:0] ea; oag_space_type sp;
    logic opc; logic [15:0] op; logic pcl;
  } oag_exp_type;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req_valid_i = 1'b0, req_word_i = 1'b0, req_work_i = 1'b0, req_long_i = 1'b0;
  oag_instr_type req_instr_i = OAG_GENERIC_INSTR;
  oag_mode_type req_mode_i = OAG_REGISTER_MODE;
  logic [7:0] req_reg_i = 8'h00, req_disp_i = 8'h00, reg_ptr_i = 8'h00, rd_data_i, d8;
  logic [15:0] req_imm_i = 16'h0000, pc_next_i = 16'h0000, v;
  logic req_ready_o, rd_o, done_o, fault_o, ea_valid_o, operand_valid_o, pc_load_o;
  oag_space_type rd_space_o, ea_space_o;
  logic [15:0] rd_addr_o, ea_o, operand_o;
  int mismatches = 0, samples_checked = 0, seed = 32'h92EC6334;
  oag_exp_type expq[$], ex;
  oag_instr_type abs_i[4] = '{OAG_ABSOLUTE_JUMP, OAG_CALL, OAG_PROGRAM_MEMORY_LOAD,
                              OAG_EXTERNAL_DATA_LOAD};
  oag_space_type abs_s[4] = '{OAG_SPACE_PC, OAG_SPACE_PC, OAG_SPACE_PROGRAM, OAG_SPACE_EXTERNAL};
  oag_instr_type ill_i[6] = '{OAG_GENERIC_INSTR, OAG_GENERIC_INSTR, OAG_ABSOLUTE_JUMP,
                              OAG_PLAIN_LOAD, OAG_PROGRAM_MEMORY_LOAD, OAG_CALL};
  oag_mode_type ill_m[6] = '{OAG_INDEXED_MODE, OAG_ABSOLUTE_ADDRESS_MODE,
    OAG_VECTORED_ADDRESS_MODE, OAG_PC_RELATIVE_MODE, OAG_LITERAL_OPERAND_MODE, OAG_INDEXED_MODE};
  localparam oag_exp_type EX_FLT = '{1'b1, 1'b0, 16'h0000, OAG_SPACE_REGISTER_FILE, 1'b0,
                                     16'h0000, 1'b0};

  oag_operand_address_generator oag_operand_address_generator_i (
    .clk_i, .resetn_i, .req_valid_i, .req_instr_i, .req_mode_i, .req_word_i, .req_work_i,
    .req_long_i, .req_reg_i, .req_disp_i, .req_imm_i, .pc_next_i, .reg_ptr_i, .rd_data_i,
    .req_ready_o, .rd_o, .rd_space_o, .rd_addr_o, .done_o, .fault_o, .ea_o, .ea_space_o,
    .ea_valid_o, .operand_o, .operand_valid_o, .pc_load_o
  );
  oag_mem_model oag_mem_model_i (
    .clk_i(clk_i), .rd_i(rd_o), .space_i(rd_space_o), .addr_i(rd_addr_o), .data_o(rd_data_i)
  );

  always #2 clk_i = ~clk_i;

  function automatic logic [15:0] mw(input logic p, input logic [15:0] a, input logic w);
    logic [15:0] b;
    b = a + 16'h0001;
    if (!w) return {8'h00, a[7:0] ^ a[15:8] ^ (p ? 8'hA5 : 8'h3C)};
    return {a[7:0] ^ a[15:8] ^ (p ? 8'hA5 : 8'h3C), b[7:0] ^ b[15:8] ^ (p ? 8'hA5 : 8'h3C)};
  endfunction : mw
  function automatic oag_exp_type ex_ea(input logic [15:0] a, input oag_space_type s,
                                        input logic p);
    return '{1'b0, 1'b1, a, s, 1'b0, 16'h0000, p};
  endfunction : ex_ea
  function automatic oag_exp_type ex_op(input logic [15:0] o);
    return '{1'b0, 1'b0, 16'h0000, OAG_SPACE_REGISTER_FILE, 1'b1, o, 1'b0};
  endfunction : ex_op

  task automatic end_of_test;
    if (expq.size() != 0) mismatches++;
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  // Flags f are word, working and long; the request stands until it is taken.
  task automatic issue(input oag_instr_type i, input oag_mode_type m, input logic [2:0] f,
    input logic [7:0] r, input logic [7:0] d, input logic [15:0] im, input oag_exp_type e);
    int n;
    expq.push_back(e);
    req_instr_i <= i;
    req_mode_i <= m;
    {req_word_i, req_work_i, req_long_i} <= f;
    req_reg_i <= r;
    req_disp_i <= d;
    req_imm_i <= im;
    req_valid_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 20);
    req_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 10);
    if (done_o !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
  endtask : issue

  always @(posedge clk_i) begin
    if (done_o === 1'b1) begin
      ex = expq.pop_front();
      `CHK("fault", ex.flt, fault_o)
      if (ex.eac) begin
        `CHK("ea", ex.ea, ea_o)
        `CHK("ea_space", ex.sp, ea_space_o)
      end
      `CHK("ea_valid", ex.eac, ea_valid_o)
      if (ex.opc) begin
        `CHK("operand", ex.op, operand_o)
      end
      `CHK("operand_valid", ex.opc, operand_valid_o)
      `CHK("pc_load", ex.pcl, pc_load_o)
    end
  end

  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    reg_ptr_i <= 8'h2B;
    issue(OAG_GENERIC_INSTR, OAG_REGISTER_MODE, 3'b000, 8'h45, 8'h00, 16'h0000,
          ex_op(mw(0, 16'h0045, 0)));
    issue(OAG_GENERIC_INSTR, OAG_REGISTER_MODE, 3'b100, 8'h46, 8'h00, 16'h0000,
          ex_op(mw(0, 16'h0046, 1)));
    issue(OAG_GENERIC_INSTR, OAG_REGISTER_MODE, 3'b010, 8'hF5, 8'h00, 16'h0000,
          ex_op(mw(0, 16'h002D, 0)));
    $display("register test done");
    issue(OAG_GENERIC_INSTR, OAG_REGISTER_INDIRECT_MODE, 3'b000, 8'h10, 8'h00, 16'h0000,
          ex_ea(mw(0, 16'h0010, 0), OAG_SPACE_REGISTER_FILE, 0));
    issue(OAG_GENERIC_INSTR, OAG_REGISTER_INDIRECT_MODE, 3'b000, 8'hF0, 8'h00, 16'h0000, EX_FLT);
    issue(OAG_PROGRAM_MEMORY_LOAD, OAG_REGISTER_INDIRECT_MODE, 3'b000, 8'h20, 8'h00, 16'h0000,
          ex_ea(mw(0, 16'h0020, 1), OAG_SPACE_PROGRAM, 0));
    issue(OAG_EXTERNAL_DATA_LOAD, OAG_REGISTER_INDIRECT_MODE, 3'b010, 8'h04, 8'h00, 16'h0000,
          ex_ea(mw(0, 16'h002C, 1), OAG_SPACE_EXTERNAL, 0));
    $display("indirect test done");
    issue(OAG_PLAIN_LOAD, OAG_INDEXED_MODE, 3'b000, 8'h03, 8'h00, 16'h00A8,
          ex_ea(16'h00A8 + mw(0, 16'h002B, 0), OAG_SPACE_REGISTER_FILE, 0));
    issue(OAG_PLAIN_LOAD, OAG_INDEXED_MODE, 3'b000, 8'h03, 8'h00, 16'h00A9, EX_FLT);
    issue(OAG_EXTERNAL_DATA_LOAD, OAG_INDEXED_MODE, 3'b000, 8'h02, 8'h80, 16'h0000,
          ex_ea(mw(0, 16'h002A, 1) - 16'h0080, OAG_SPACE_EXTERNAL, 0));
    issue(OAG_PROGRAM_MEMORY_LOAD, OAG_INDEXED_MODE, 3'b000, 8'h02, 8'h7F, 16'h0000,
          ex_ea(mw(0, 16'h002A, 1) + 16'h007F, OAG_SPACE_PROGRAM, 0));
    issue(OAG_PROGRAM_MEMORY_LOAD, OAG_INDEXED_MODE, 3'b001, 8'h02, 8'h00, 16'h1000,
          ex_ea(mw(0, 16'h002A, 1) + 16'h1000, OAG_SPACE_PROGRAM, 0));
    $display("indexed test done");
    for (int k = 0; k < 4; k++) begin
      v = 16'($random(seed));
      issue(abs_i[k], OAG_ABSOLUTE_ADDRESS_MODE, 3'b000, 8'h00, 8'h00, v, ex_ea(v, abs_s[k], k < 2));
    end
    issue(OAG_CALL, OAG_VECTORED_ADDRESS_MODE, 3'b000, 8'h00, 8'hFE, 16'hFFFF,
          ex_ea(mw(1, 16'h00FE, 1), OAG_SPACE_PC, 1));
    $display("absolute and vectored test done");
    for (int k = 0; k < 6; k++) begin
      v = 16'($random(seed));
      d8 = (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : v[15:8];
      pc_next_i <= v;
      issue(oag_instr_type'(int'(OAG_BIT_TEST_FALSE_BRANCH) + k), OAG_PC_RELATIVE_MODE, 3'b000,
            8'h00, d8, 16'h0000, ex_ea(v + {{8{d8[7]}}, d8}, OAG_SPACE_PC, 1));
    end
    v = 16'($random(seed));
    issue(OAG_PLAIN_LOAD, OAG_LITERAL_OPERAND_MODE, 3'b000, 8'h00, 8'h00, v, ex_op({8'h00, v[7:0]}));
    issue(OAG_GENERIC_INSTR, OAG_LITERAL_OPERAND_MODE, 3'b100, 8'h00, 8'h00, v, ex_op(v));
    $display("relative and literal test done");
    for (int k = 0; k < 6; k++) issue(ill_i[k], ill_m[k], 3'b000, 8'h02, 8'h10, 16'h1234, EX_FLT);
    $display("refused mode test done");
    @(posedge clk_i);
    end_of_test();
  end
endmodule : oag_operand_address_generator_bench
